// file: pcti_pin_model.sv
// pcti_pin_model.sv: pin-side model for capture inputs and the event line
`include "pcti_regs.svh"
module pcti_pin_model (
    // clock
    input wire logic i_core_clk,
    // channel pins as driven by the timer
    input wire logic [`PCTI_NCH-1:0] i_pin_out,
    input wire logic [`PCTI_NCH-1:0] i_pin_oe,
    // resolved pin levels and event line
    output logic [`PCTI_NCH-1:0] o_pin,
    output logic o_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`PCTI_NCH-1:0] ext_lvl = '0;
    initial o_evt = 1'b0;
    // the timer owns a pin only while its enable is high
    assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & ext_lvl);
    // level applied from outside to one channel pin
    task set_pin(input int ch, input logic lvl);
        ext_lvl[ch] = lvl;
    endtask
    // event pulse held two clocks so the synchroniser cannot miss it
    task pulse_evt;
        o_evt = 1'b1;
        repeat (2) @(posedge i_core_clk);
        #5 o_evt = 1'b0;
        repeat (2) @(posedge i_core_clk);
        #5;
    endtask
endmodule // pcti_pin_model

// file: pcti_pkg.sv
// pcti_pkg.sv: types and shared functions of the timer group
`include "pcti_regs.svh"
package pcti_pkg;

    // counting source of the main timer
    typedef enum logic [1:0] {
        PCTI_STOP = 2'b00,
        PCTI_TIMING = 2'b01,
        PCTI_EVENT = 2'b10
    } pcti_mode_e;

    typedef logic [`PCTI_PRE_W-1:0] pcti_pre_t;

    // prescaler step: divide by div+1, wraps on reaching div
    function automatic pcti_pre_t pcti_pre_next(input pcti_pre_t cnt, input pcti_pre_t div);
        pcti_pre_next = (cnt == div) ? '0 : pcti_pre_t'(cnt + `PCTI_PRE_ONE);
    endfunction

endpackage

// file: pcti_regs.svh
// pcti_regs.svh: widths, channel counts and fixed values for the timer group
`ifndef PCTI_REGS_SVH
`define PCTI_REGS_SVH
`define PCTI_MAIN_W 16
`define PCTI_SMALL_W 8
`define PCTI_PRE_W 8
`define PCTI_NCH 5
`define PCTI_PRE_ONE 8'h01
`define PCTI_MAIN_ONE 16'h0001
`define PCTI_SMALL_ONE 8'h01
`endif

// file: pcti_small_timer.sv
// pcti_small_timer.sv: 8-bit timer with prescaler, period and one PWM channel
`include "pcti_regs.svh"
module pcti_small_timer import pcti_pkg::*; (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // configuration
    input wire logic i_en,
    input wire logic [`PCTI_PRE_W-1:0] i_pre_div,
    input wire logic [`PCTI_SMALL_W-1:0] i_period,
    input wire logic [`PCTI_SMALL_W-1:0] i_cmp,
    // status and output
    output logic [`PCTI_SMALL_W-1:0] o_cnt,
    output logic o_pwm,
    output logic o_wrap
);
    pcti_pre_t pre_r, pre_nxt;
    logic [`PCTI_SMALL_W-1:0] cnt_r, cnt_nxt;
    logic pwm_r, pwm_nxt, wrap_r, wrap_nxt, tick;

    // ----------------------------------------------------------------
    // prescaler, counter and channel
    // ----------------------------------------------------------------
    // compare of zero gives a constant low output, a 0 % duty cycle
    always_comb begin
        tick = i_en && (pre_r == i_pre_div);
        pre_nxt = i_en ? pcti_pre_next(pre_r, i_pre_div) : '0;
        cnt_nxt = cnt_r;
        pwm_nxt = i_en ? pwm_r : 1'b0;
        wrap_nxt = 1'b0;
        if (tick) begin
            if (cnt_r == i_period) begin
                cnt_nxt = '0;
                wrap_nxt = 1'b1;
            end else begin
                cnt_nxt = `PCTI_SMALL_W'(cnt_r + `PCTI_SMALL_ONE);
            end
            if (cnt_nxt == i_cmp) begin
                pwm_nxt = 1'b0;
            end else if (cnt_nxt == '0) begin
                pwm_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pre_r <= '0;
            cnt_r <= '0;
            pwm_r <= 1'b0;
            wrap_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            pwm_r <= pwm_nxt;
            wrap_r <= wrap_nxt;
        end
    end

    assign o_cnt = cnt_r;
    assign o_pwm = pwm_r;
    assign o_wrap = wrap_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_S_WRAP: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        tick && (cnt_r == i_period) |=> (cnt_r == '0) && wrap_r)
        else $error("small timer did not restart at period");
    AST_S_PWM: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        i_en && tick && (cnt_nxt == i_cmp) |=> !pwm_r)
        else $error("small timer output not low at compare match");

endmodule // pcti_small_timer

// file: pcti_timers.sv
// pcti_timers.sv: 16-bit capture/PWM timer with two 8-bit timers and IR gating
// Overview of operation
// - main timer 16-bit: timing, event counting, PWM
// - main timer prescaled in timing mode, bounded by 16-bit period
// - five channels, each own 16-bit compare
// - each channel selects PWM or edge capture
// - IR mode counts first small timer periods
// - IR mode pin is main AND small output
// - small timers: 8-bit count, prescaler, period
// - each small timer has one 8-bit compare
// - small timer channel drives a PWM output
`include "pcti_regs.svh"
module pcti_timers import pcti_pkg::*; (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // main timer configuration
    input wire pcti_mode_e i_w_mode,
    input wire logic [`PCTI_PRE_W-1:0] i_w_pre_div,
    input wire logic [`PCTI_MAIN_W-1:0] i_w_period,
    input wire logic i_infrared_carrier_gating_mode,
    input wire logic i_evt_pin,
    // main timer channels
    input wire logic [`PCTI_NCH-1:0][`PCTI_MAIN_W-1:0] i_ch_cmp,
    input wire logic [`PCTI_NCH-1:0] i_ch_cap_sel,
    input wire logic [`PCTI_NCH-1:0] i_ch_cap_fall,
    input wire logic [`PCTI_NCH-1:0] i_cap_flag_clr,
    input wire logic [`PCTI_NCH-1:0] i_ch_pin,
    output logic [`PCTI_NCH-1:0] o_ch_pin,
    output logic [`PCTI_NCH-1:0] o_ch_pin_oe,
    output logic [`PCTI_NCH-1:0][`PCTI_MAIN_W-1:0] o_ch_cap_val,
    output logic [`PCTI_NCH-1:0] o_cap_flag,
    output logic [`PCTI_MAIN_W-1:0] o_w_cnt,
    // first small timer
    input wire logic i_s0_en,
    input wire logic [`PCTI_PRE_W-1:0] i_s0_pre_div,
    input wire logic [`PCTI_SMALL_W-1:0] i_s0_period,
    input wire logic [`PCTI_SMALL_W-1:0] i_s0_cmp,
    output logic o_s0_pin,
    // second small timer
    input wire logic i_s1_en,
    input wire logic [`PCTI_PRE_W-1:0] i_s1_pre_div,
    input wire logic [`PCTI_SMALL_W-1:0] i_s1_period,
    input wire logic [`PCTI_SMALL_W-1:0] i_s1_cmp,
    output logic o_s1_pin
);
    pcti_pre_t pre_r, pre_nxt;
    logic [`PCTI_MAIN_W-1:0] cnt_r, cnt_nxt;
    logic [`PCTI_NCH-1:0] pwm_r, pwm_nxt, pin_r, pin_nxt, oe_r, oe_nxt;
    logic [`PCTI_NCH-1:0][`PCTI_MAIN_W-1:0] cap_r, cap_nxt;
    logic [`PCTI_NCH-1:0] flag_r, flag_nxt, cap_evt;
    logic [`PCTI_NCH-1:0] cs1_r, cs2_r, cs3_r;
    logic es1_r, es2_r, es3_r, evt_rise, pre_tick, tick;
    logic s0_pwm, s0_wrap;

    // ----------------------------------------------------------------
    // small timers
    // ----------------------------------------------------------------
    pcti_small_timer u_s0 (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_en(i_s0_en),
        .i_pre_div(i_s0_pre_div),
        .i_period(i_s0_period),
        .i_cmp(i_s0_cmp),
        .o_cnt(),
        .o_pwm(s0_pwm),
        .o_wrap(s0_wrap)
    );

    pcti_small_timer u_s1 (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_en(i_s1_en),
        .i_pre_div(i_s1_pre_div),
        .i_period(i_s1_period),
        .i_cmp(i_s1_cmp),
        .o_cnt(),
        .o_pwm(o_s1_pin),
        .o_wrap()
    );

    assign o_s0_pin = s0_pwm;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // third stage only feeds edge detection, first stage stays private
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs1_r <= '0;
            cs2_r <= '0;
            cs3_r <= '0;
            es1_r <= 1'b0;
            es2_r <= 1'b0;
            es3_r <= 1'b0;
        end else begin
            cs1_r <= i_ch_pin;
            cs2_r <= cs1_r;
            cs3_r <= cs2_r;
            es1_r <= i_evt_pin;
            es2_r <= es1_r;
            es3_r <= es2_r;
        end
    end

    // ----------------------------------------------------------------
    // main counter
    // ----------------------------------------------------------------
    // IR mode replaces the tick source but keeps the mode's run/stop
    always_comb begin
        evt_rise = es2_r && !es3_r;
        pre_tick = (i_w_mode == PCTI_TIMING) && (pre_r == i_w_pre_div);
        pre_nxt = (i_w_mode == PCTI_TIMING) ? pcti_pre_next(pre_r, i_w_pre_div) : '0;
        unique case (i_w_mode)
            PCTI_STOP: tick = 1'b0;
            PCTI_TIMING: tick = i_infrared_carrier_gating_mode ? s0_wrap : pre_tick;
            PCTI_EVENT: tick = i_infrared_carrier_gating_mode ? s0_wrap : evt_rise;
            default: tick = 1'b0;
        endcase
        cnt_nxt = cnt_r;
        if (tick) begin
            cnt_nxt = (cnt_r == i_w_period) ? '0 : `PCTI_MAIN_W'(cnt_r + `PCTI_MAIN_ONE);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pre_r <= '0;
            cnt_r <= '0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign o_w_cnt = cnt_r;

    // ----------------------------------------------------------------
    // channels: compare/PWM or capture
    // ----------------------------------------------------------------
    // set beats clear on a capture flag so an edge is never lost
    always_comb begin
        for (int i = 0; i < `PCTI_NCH; i++) begin
            cap_evt[i] = i_ch_cap_sel[i] &&
                (i_ch_cap_fall[i] ? (cs3_r[i] && !cs2_r[i]) : (cs2_r[i] && !cs3_r[i]));
            cap_nxt[i] = cap_evt[i] ? cnt_r : cap_r[i];
            flag_nxt[i] = cap_evt[i] || (flag_r[i] && !i_cap_flag_clr[i]);
            oe_nxt[i] = !i_ch_cap_sel[i];
            pwm_nxt[i] = (i_w_mode inside {PCTI_TIMING, PCTI_EVENT}) ? pwm_r[i] : 1'b0; // code 11 stops like 00
            if (tick) begin
                if (cnt_nxt == i_ch_cmp[i]) begin
                    pwm_nxt[i] = 1'b0;
                end else if (cnt_nxt == '0) begin
                    pwm_nxt[i] = 1'b1;
                end
            end
            pin_nxt[i] = i_infrared_carrier_gating_mode ? (pwm_r[i] && s0_pwm) : pwm_r[i];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cap_r <= '0;
            flag_r <= '0;
            oe_r <= '0;
            pwm_r <= '0;
            pin_r <= '0;
        end else begin
            cap_r <= cap_nxt;
            flag_r <= flag_nxt;
            oe_r <= oe_nxt;
            pwm_r <= pwm_nxt;
            pin_r <= pin_nxt;
        end
    end

    assign o_ch_cap_val = cap_r;
    assign o_cap_flag = flag_r;
    assign o_ch_pin = pin_r;
    assign o_ch_pin_oe = oe_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    AST_WRAP: assert property (tick && (cnt_r == i_w_period) |=> cnt_r == '0)
        else $error("main counter did not restart at period");
    AST_INC: assert property (tick && (cnt_r != i_w_period)
        |=> cnt_r == `PCTI_MAIN_W'($past(cnt_r) + `PCTI_MAIN_ONE))
        else $error("main counter did not advance by one");
    AST_HOLD: assert property (!tick |=> $stable(cnt_r))
        else $error("main counter moved without a tick");
    AST_STOP: assert property ((i_w_mode == PCTI_STOP) [*2] |-> $stable(cnt_r) && (pwm_r == '0))
        else $error("main timer active while stopped");
    AST_IR_TICK: assert property (i_infrared_carrier_gating_mode && (i_w_mode == PCTI_TIMING)
        |-> tick == s0_wrap)
        else $error("IR mode not counting small timer periods");
    AST_IR_AND: assert property (i_infrared_carrier_gating_mode
        |=> o_ch_pin == ($past(pwm_r) & {`PCTI_NCH{$past(s0_pwm)}}))
        else $error("IR pin is not the AND of both outputs");

    for (genvar g = 0; g < `PCTI_NCH; g++) begin : g_chk
        AST_CAP: assert property (cap_evt[g] |=> (o_ch_cap_val[g] == $past(cnt_r)) && o_cap_flag[g])
            else $error("capture did not store count or raise flag");
        AST_CAP_RISE: assert property (i_ch_cap_sel[g] && !i_ch_cap_fall[g]
            && $rose(cs2_r[g]) && $past(cs2_r[g]) == cs3_r[g] |-> cap_evt[g])
            else $error("rising edge not captured");
        AST_PWM_LOW: assert property (tick && (cnt_nxt == i_ch_cmp[g]) |=> !pwm_r[g] ##1
            (!i_infrared_carrier_gating_mode || !o_ch_pin[g]))
            else $error("channel output not low after compare match");
        AST_OE: assert property (i_ch_cap_sel[g] |=> !o_ch_pin_oe[g])
            else $error("capture channel drives its pin");
    end

endmodule // pcti_timers

// file: tb.sv
// tb.sv: self-checking bench for the timer group
module tb import pcti_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_b = 1'b0, ir = 1'b0, s0e = 1'b0, s1e = 1'b0, evt, s0_pin, s1_pin;
    pcti_mode_e mode = PCTI_STOP;
    logic [7:0] wdiv = 8'h00, s0d = 8'h00, s0p = 8'h00, s0c = 8'h00, s1d = 8'h00, s1p = 8'h00, s1c = 8'h00;
    logic [15:0] wper = 16'h0000, cnt, c0;
    logic [4:0][15:0] cmp = '0, cap_val;
    logic [4:0] sel = 5'h00, fall = 5'h00, clr = 5'h00, pin_in, pin_out, oe, flag;
    int n_errors = 0, checked = 0, k;
    int hc[7];
    always #50 clk = ~clk;
    pcti_timers dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_w_mode(mode), .i_w_pre_div(wdiv),
        .i_w_period(wper), .i_infrared_carrier_gating_mode(ir), .i_evt_pin(evt), .i_ch_cmp(cmp),
        .i_ch_cap_sel(sel), .i_ch_cap_fall(fall), .i_cap_flag_clr(clr), .i_ch_pin(pin_in),
        .o_ch_pin(pin_out), .o_ch_pin_oe(oe), .o_ch_cap_val(cap_val), .o_cap_flag(flag), .o_w_cnt(cnt),
        .i_s0_en(s0e), .i_s0_pre_div(s0d), .i_s0_period(s0p), .i_s0_cmp(s0c), .o_s0_pin(s0_pin),
        .i_s1_en(s1e), .i_s1_pre_div(s1d), .i_s1_period(s1p), .i_s1_cmp(s1c), .o_s1_pin(s1_pin));
    pcti_pin_model pm (.i_core_clk(clk), .i_pin_out(pin_out), .i_pin_oe(oe), .o_pin(pin_in), .o_evt(evt));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // inputs always move 5 ns after the rising edge, clear of sampling
    task step(input int n = 1);
        repeat (n) begin
            @(posedge clk);
            #5;
        end
    endtask
    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // high-cycle counts of the five channel pins and both small pins
    task hi(input int n);
        hc = '{default: 0};
        repeat (n) begin
            step();
            for (int i = 0; i < 5; i++) hc[i] += pin_out[i];
            hc[5] += s0_pin;
            hc[6] += s1_pin;
        end
    endtask
    task conclude;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_timing;
        mode = PCTI_TIMING;
        wdiv = 8'h01;
        wper = 16'h0002;
        k = 0;
        while (cnt !== 16'h0001 && k < 20) begin
            step();
            k++;
        end
        check("cnt", cnt, 16'h0001);
        step();
        check("cnt hold", cnt, 16'h0001);
        step();
        check("cnt", cnt, 16'h0002);
        step(2);
        check("cnt wrap", cnt, 16'h0000);
    endtask
    // 40 clocks span four main and five small periods exactly
    task t_pwm;
        wdiv = 8'h00;
        wper = 16'h0009;
        for (int i = 0; i < 5; i++) cmp[i] = 16'(i + 1);
        {s0e, s0p, s0c, s1e, s1d, s1p, s1c} = {1'b1, 8'h07, 8'h02, 1'b1, 8'h01, 8'h03, 8'h01};
        step(30);
        check("oe", 16'(oe), 16'h001F);
        hi(40);
        for (int i = 0; i < 5; i++) check("pwm high", 16'(hc[i]), 16'(4 * (i + 1)));
        check("s0 high", 16'(hc[5]), 16'h000A);
        check("s1 high", 16'(hc[6]), 16'h000A);
        s1e = 1'b0;
        step(3);
        check("s1 off", 16'(s1_pin), 16'h0000);
    endtask
    task t_cap(input int ch, input logic f);
        wper = 16'hFFFF;
        sel[ch] = 1'b1;
        fall[ch] = f;
        pm.set_pin(ch, f);
        step(4);
        // handing the pin over can show a stray edge of the old PWM level, so clear first
        clr[ch] = 1'b1;
        step();
        clr[ch] = 1'b0;
        check("flag idle", 16'(flag[ch]), 16'h0000);
        c0 = cnt;
        pm.set_pin(ch, ~f);
        k = 0;
        while (flag[ch] !== 1'b1 && k < 8) begin
            step();
            k++;
        end
        check("oe off", 16'(oe[ch]), 16'h0000);
        check("cap flag", 16'(flag[ch]), 16'h0001);
        check("cap val", cap_val[ch], 16'(c0 + 16'h0002));
        clr[ch] = 1'b1;
        step();
        clr[ch] = 1'b0;
        step();
        check("flag clr", 16'(flag[ch]), 16'h0000);
    endtask
    task t_evt;
        mode = PCTI_EVENT;
        c0 = cnt;
        repeat (3) pm.pulse_evt();
        step(4);
        check("evt cnt", cnt, 16'(c0 + 16'h0003));
    endtask
    // envelope of the main channel stays high, so the pin shows the carrier
    task t_ir;
        // mid-run reset: a count left above the short period would run on to overflow
        rst_b = 1'b0;
        mode = PCTI_TIMING;
        ir = 1'b1;
        sel = 5'h00;
        wper = 16'h0001;
        s0e = 1'b1;
        s0p = 8'h03;
        s0c = 8'h02;
        cmp[0] = 16'h0005;
        step();
        check("reset cnt", cnt, 16'h0000);
        rst_b = 1'b1;
        step(30);
        c0 = cnt;
        k = 0;
        while (cnt === c0 && k < 20) begin
            step();
            k++;
        end
        c0 = cnt;
        k = 0;
        while (cnt === c0 && k < 20) begin
            step();
            k++;
        end
        check("ir tick", 16'(k), 16'h0004);
        hi(8);
        check("ir s0", 16'(hc[5]), 16'h0004);
        check("ir pin", 16'(hc[0]), 16'h0004);
        mode = PCTI_STOP;
        c0 = cnt;
        step(3);
        check("stop cnt", cnt, c0);
        check("stop pins", 16'(pin_out), 16'h0000);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #5 rst_b = 1'b1;
        t_timing();
        t_pwm();
        t_cap(1, 1'b0);
        t_cap(3, 1'b1);
        t_evt();
        t_ir();
        conclude();
    end
    // a hang is cut off at 2000 cycles, well past the 170 or so cycles the tests need
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule // tb
